// [src/ccd_decoder.sv]
/*
 * Configuration command decoder: takes command bytes, keeps the interrupt
 * drive type, bus base address, keypad/IO split and general pin modes.
 * Assumes bytes arrive as single-cycle strobes, already deframed, and that
 * the keypad block reports pending data as a level.
 */
`timescale 1ns/100ps
module ccd_decoder #(
    parameter int WRITE_CYC = ccd_pkg::NV_WRITE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic key_pending,
    output logic nv_busy,
    output logic nv_commit,
    output logic int_open_drain,
    output logic int_o,
    output logic int_oe,
    output logic [7:0] base_addr,
    output logic [7:0] keypad_io,
    output ccd_pkg::ccd_keypad_t keypad_size,
    output logic aux_drain_output_en,
    output logic general_pin_a_en,
    output logic general_pin_b_en,
    output logic general_pin_c_en,
    output logic [7:0] general_pin_a_mode,
    output logic [7:0] general_pin_b_mode,
    output logic general_pin_a_pullup,
    output logic general_pin_b_pullup,
    output logic general_pin_a_dir_out,
    output logic general_pin_b_dir_out,
    output logic analog_channel_a_en,
    output logic analog_channel_b_en
);
    import ccd_pkg::*;

    typedef enum logic [1:0] {
        CCD_IDLE,
        CCD_PARAM
    } ccd_state_t;

    ccd_nv_if nv ();

    ccd_state_t state_r, state_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic armed_r, armed_nxt;
    logic keep_r, keep_nxt;
    logic oc_r, oc_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] kio_r, kio_nxt;
    logic [7:0] mode_a_r, mode_a_nxt;
    logic [7:0] mode_b_r, mode_b_nxt;
    logic commit_r, commit_nxt;
    logic kio_legal;
    logic mode_legal;
    logic a_en, b_en;

    ccd_nv_timer #(
        .WRITE_CYC(WRITE_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .nv(nv.timer)
    );

    ccd_kio_decode u_kio (
        .kio(kio_r),
        .keypad(keypad_size),
        .aux_en(aux_drain_output_en),
        .pin_a_en(a_en),
        .pin_b_en(b_en),
        .pin_c_en(general_pin_c_en)
    );

    // Legal parameter values; others are dropped rather than guessed at
    assign kio_legal = (byte_data == KIO_4X4) || (byte_data == KIO_4X3) ||
                       (byte_data == KIO_4X2) || (byte_data == KIO_4X1) ||
                       (byte_data == KIO_NONE);
    assign mode_legal = (byte_data == MODE_DIN) || (byte_data == MODE_DOUT) ||
                        (byte_data == MODE_AIN) || (byte_data == MODE_DIN_PU) ||
                        (byte_data == MODE_AIN_PU);

    // Byte interpreter: opcode, optional value byte, remember arming
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        armed_nxt = armed_r;
        keep_nxt = keep_r;
        oc_nxt = oc_r;
        addr_nxt = addr_r;
        kio_nxt = kio_r;
        mode_a_nxt = mode_a_r;
        mode_b_nxt = mode_b_r;
        commit_nxt = 1'b0;
        if (byte_valid) begin
            case (state_r)
                CCD_IDLE: begin
                    armed_nxt = 1'b0;
                    case (byte_data)
                        CMD_REMEMBER: armed_nxt = 1'b1;
                        CMD_INT_OC: begin
                            oc_nxt = 1'b1;
                            // A busy store would drop the start, so no commit then
                            commit_nxt = armed_r && !nv.busy;
                        end
                        CMD_INT_PP: begin
                            oc_nxt = 1'b0;
                            commit_nxt = armed_r && !nv.busy;
                        end
                        CMD_BASE_ADDR, CMD_KEYPAD_IO, CMD_PIN_A, CMD_PIN_B: begin
                            // Remember flag travels with the opcode to its value
                            cmd_nxt = byte_data;
                            keep_nxt = armed_r;
                            state_nxt = CCD_PARAM;
                        end
                        default: armed_nxt = 1'b0;
                    endcase
                end
                CCD_PARAM: begin
                    state_nxt = CCD_IDLE;
                    if (keep_r && !nv.busy) begin
                        case (cmd_r)
                            CMD_BASE_ADDR: begin
                                addr_nxt = byte_data;
                                commit_nxt = 1'b1;
                            end
                            CMD_KEYPAD_IO: begin
                                if (kio_legal) begin
                                    kio_nxt = byte_data;
                                    commit_nxt = 1'b1;
                                end
                            end
                            CMD_PIN_A: begin
                                if (a_en && mode_legal) begin
                                    mode_a_nxt = byte_data;
                                    commit_nxt = 1'b1;
                                end
                            end
                            CMD_PIN_B: begin
                                if (b_en && mode_legal) begin
                                    mode_b_nxt = byte_data;
                                    commit_nxt = 1'b1;
                                end
                            end
                            default: commit_nxt = 1'b0;
                        endcase
                    end
                    keep_nxt = 1'b0;
                end
                default: state_nxt = CCD_IDLE;
            endcase
        end
    end

    // Settings come up at factory defaults
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CCD_IDLE;
            cmd_r <= 8'h00;
            armed_r <= 1'b0;
            keep_r <= 1'b0;
            oc_r <= RST_INT_OC;
            addr_r <= RST_BASE_ADDR;
            kio_r <= RST_KEYPAD_IO;
            mode_a_r <= MODE_DIN;
            mode_b_r <= MODE_DIN;
            commit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            armed_r <= armed_nxt;
            keep_r <= keep_nxt;
            oc_r <= oc_nxt;
            addr_r <= addr_nxt;
            kio_r <= kio_nxt;
            mode_a_r <= mode_a_nxt;
            mode_b_r <= mode_b_nxt;
            commit_r <= commit_nxt;
        end
    end

    assign nv.start = commit_r;
    assign nv_commit = commit_r;
    assign nv_busy = nv.busy;

    // Interrupt pin: open drain only pulls low; push-pull drives both levels
    assign int_o = !key_pending;
    assign int_oe = oc_r ? key_pending : 1'b1;
    assign int_open_drain = oc_r;

    assign base_addr = addr_r;
    assign keypad_io = kio_r;
    assign general_pin_a_en = a_en;
    assign general_pin_b_en = b_en;
    assign general_pin_a_mode = mode_a_r;
    assign general_pin_b_mode = mode_b_r;
    // Pin modes only act while the pin is granted by the keypad split
    assign general_pin_a_pullup = a_en && mode_a_r[2];
    assign general_pin_b_pullup = b_en && mode_b_r[2];
    assign general_pin_a_dir_out = a_en && (mode_a_r == MODE_DOUT);
    assign general_pin_b_dir_out = b_en && (mode_b_r == MODE_DOUT);
    // No analog path exists; analog codes leave the pin an input, with pull-up for 0x06
    assign analog_channel_a_en = 1'b0;
    assign analog_channel_b_en = 1'b0;
endmodule

// [shared/ccd_pkg.sv]
/*
 * Constants and types for the configuration command decoder.
 * Assumes one 40 MHz clock and a byte stream already framed by the host link.
 */
// Function
// - Command 0x2A selects open-collector interrupt drive; this is the power-up default.
// - Interrupt line is active whenever keypad data waits to be read.
// - Command 0x22 selects push-pull interrupt drive, I2C mode only; the decoder has no mode input and accepts it in every case.
// - Remembered 0x91 loads the I2C base address; default 0x50.
// - Remembered 0xE0 plus value byte reconfigures keypad, aux output, general pins.
// - Value 0x00 4x4, 0x01 4x3+aux, 0x03 +pin A, 0x07 +pin B, 0x0F all.
// - Default is 4x3 keypad, aux output on, general and analog pins off.
// - Remembered commands commit to non-volatile store, busy about 6 ms.
// - Remembered 0xE3 plus value sets pin A mode from the five defined codes.
// - Analog modes 0x02 and 0x06 give no analog function.
// - Pin A usable only with eight keys or fewer.
// - Remembered 0xE4 plus value sets pin B mode; default digital input.
// - Pin B usable only with four keys or fewer.
package ccd_pkg;
    localparam logic [7:0] CMD_REMEMBER = 8'h8D;
    localparam logic [7:0] CMD_INT_OC = 8'h2A;
    localparam logic [7:0] CMD_INT_PP = 8'h22;
    localparam logic [7:0] CMD_BASE_ADDR = 8'h91;
    localparam logic [7:0] CMD_KEYPAD_IO = 8'hE0;
    localparam logic [7:0] CMD_PIN_A = 8'hE3;
    localparam logic [7:0] CMD_PIN_B = 8'hE4;
    localparam logic [7:0] KIO_4X4 = 8'h00;
    localparam logic [7:0] KIO_4X3 = 8'h01;
    localparam logic [7:0] KIO_4X2 = 8'h03;
    localparam logic [7:0] KIO_4X1 = 8'h07;
    localparam logic [7:0] KIO_NONE = 8'h0F;
    localparam logic [7:0] MODE_DIN = 8'h00;
    localparam logic [7:0] MODE_DOUT = 8'h01;
    localparam logic [7:0] MODE_AIN = 8'h02;
    localparam logic [7:0] MODE_DIN_PU = 8'h04;
    localparam logic [7:0] MODE_AIN_PU = 8'h06;
    localparam logic [7:0] RST_BASE_ADDR = 8'h50;
    localparam logic [7:0] RST_KEYPAD_IO = KIO_4X3;
    localparam logic RST_INT_OC = 1'b1;
    localparam int CLK_HZ = 40_000_000;
    localparam int NV_WRITE_US = 6000;
    localparam int NV_WRITE_CYC = (CLK_HZ / 1_000_000) * NV_WRITE_US;
    localparam int NV_CNT_W = 18;

    typedef enum logic [2:0] {
        CCD_KEY_4X4,
        CCD_KEY_4X3,
        CCD_KEY_4X2,
        CCD_KEY_4X1,
        CCD_KEY_NONE
    } ccd_keypad_t;
endpackage

// [shared/ccd_nv_if.sv]
/*
 * Handshake between the decoder and its non-volatile write timer.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/100ps
interface ccd_nv_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport timer (input start, output busy);
endinterface

// [src/ccd_nv_timer.sv]
/*
 * Busy timer that models the commit time of a remembered setting.
 * Assumes start is a one-cycle pulse; starts while busy are ignored.
 */
`timescale 1ns/100ps
module ccd_nv_timer #(
    parameter int WRITE_CYC = ccd_pkg::NV_WRITE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    ccd_nv_if.timer nv
);
    import ccd_pkg::*;

    logic [NV_CNT_W-1:0] cnt_r;
    logic [NV_CNT_W-1:0] cnt_nxt;

    // Load on start, count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end else if (nv.start) begin
            cnt_nxt = NV_CNT_W'(WRITE_CYC);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign nv.busy = (cnt_r != '0);
endmodule

// [src/ccd_kio_decode.sv]
/*
 * Splits the keypad/IO value into keypad size and pin enables.
 * Assumes the value was checked as one of the five legal codes.
 */
`timescale 1ns/100ps
module ccd_kio_decode (
    input wire logic [7:0] kio,
    output ccd_pkg::ccd_keypad_t keypad,
    output logic aux_en,
    output logic pin_a_en,
    output logic pin_b_en,
    output logic pin_c_en
);
    import ccd_pkg::*;

    // Shared port pins: fewer keypad columns free more pins
    always_comb begin
        keypad = CCD_KEY_4X3;
        aux_en = 1'b1;
        pin_a_en = 1'b0;
        pin_b_en = 1'b0;
        pin_c_en = 1'b0;
        case (kio)
            KIO_4X4: begin
                keypad = CCD_KEY_4X4;
                aux_en = 1'b0;
            end
            KIO_4X3: keypad = CCD_KEY_4X3;
            KIO_4X2: begin
                keypad = CCD_KEY_4X2;
                pin_a_en = 1'b1;
            end
            KIO_4X1: begin
                keypad = CCD_KEY_4X1;
                pin_a_en = 1'b1;
                pin_b_en = 1'b1;
            end
            KIO_NONE: begin
                keypad = CCD_KEY_NONE;
                pin_a_en = 1'b1;
                pin_b_en = 1'b1;
                pin_c_en = 1'b1;
            end
            default: keypad = CCD_KEY_4X3;
        endcase
    end
endmodule

// [testbench/ccd_decoder_chk.sv]
/* Assertion checker for the command decoder.
   Assumes it is bound to ccd_decoder and sees only its ports. */
`timescale 1ns/100ps
module ccd_decoder_chk #(
    parameter int WRITE_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic key_pending,
    input wire logic nv_busy,
    input wire logic nv_commit,
    input wire logic int_open_drain,
    input wire logic int_o,
    input wire logic int_oe,
    input wire logic [7:0] keypad_io,
    input wire logic general_pin_a_en,
    input wire logic general_pin_b_en,
    input wire logic analog_channel_a_en,
    input wire logic analog_channel_b_en
);
    import ccd_pkg::*;
    logic [17:0] busy_cnt_r;
    logic [17:0] busy_cnt_nxt;
    logic param_r;
    logic param_nxt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Length of the current busy stretch
    always_comb begin
        busy_cnt_nxt = nv_busy ? busy_cnt_r + 18'h00001 : 18'h00000;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_r <= 18'h00000;
            param_r <= 1'b0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
            param_r <= param_nxt;
        end
    end
    // Next byte is a value byte; opcode codes inside values are not commands
    always_comb begin
        param_nxt = param_r;
        if (byte_valid) begin
            param_nxt = !param_r && (byte_data inside {CMD_BASE_ADDR, CMD_KEYPAD_IO,
                CMD_PIN_A, CMD_PIN_B});
        end
    end
    // Armed keypad write; a busy store would drop the value
    sequence s_kio_write;
        byte_valid && !param_r && byte_data == CMD_REMEMBER
        ##1 byte_valid && byte_data == CMD_KEYPAD_IO
        ##1 byte_valid && byte_data == KIO_4X1 && !nv_busy;
    endsequence
    a_int_level: assert property (int_o == !key_pending)
        else $error("interrupt level wrong");
    a_int_drive: assert property (int_oe == (int_open_drain ? key_pending : 1'b1))
        else $error("interrupt enable wrong");
    a_oc_select: assert property (byte_valid && !param_r && byte_data == CMD_INT_OC
        |=> int_open_drain) else $error("open drain not set");
    a_pp_select: assert property (byte_valid && !param_r && byte_data == CMD_INT_PP
        |=> !int_open_drain) else $error("push pull not set");
    a_kio_write: assert property (s_kio_write |=> keypad_io == KIO_4X1 && nv_commit)
        else $error("keypad write lost");
    a_kio_commit: assert property (!$stable(keypad_io) |-> nv_commit)
        else $error("keypad change without commit");
    a_busy_follows: assert property (nv_commit |=> nv_busy)
        else $error("busy missing after commit");
    a_busy_length: assert property ($fell(nv_busy) |-> int'(busy_cnt_r) == WRITE_CYC)
        else $error("busy length wrong");
    a_pin_a_gate: assert property (general_pin_a_en |-> keypad_io inside {8'h03, 8'h07, 8'h0F})
        else $error("pin a enabled wrongly");
    a_pin_b_gate: assert property (general_pin_b_en |-> keypad_io inside {8'h07, 8'h0F})
        else $error("pin b enabled wrongly");
    a_no_analog: assert property (!analog_channel_a_en && !analog_channel_b_en)
        else $error("analog enabled");
endmodule
bind ccd_decoder ccd_decoder_chk #(.WRITE_CYC(WRITE_CYC)) chk_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data), .key_pending(key_pending),
    .nv_busy(nv_busy), .nv_commit(nv_commit), .int_open_drain(int_open_drain), .int_o(int_o),
    .int_oe(int_oe), .keypad_io(keypad_io), .general_pin_a_en(general_pin_a_en),
    .general_pin_b_en(general_pin_b_en), .analog_channel_a_en(analog_channel_a_en),
    .analog_channel_b_en(analog_channel_b_en));

// [testbench/ccd_host_model.sv]
/* Host model: sends command bytes to the decoder.
   Assumes bytes are launched on the falling edge of clk_sys. */
`timescale 1ns/100ps
module ccd_host_model (
    input wire logic clk_sys,
    input wire logic nv_busy,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    // Back to back bytes, first byte highest; may wait out the store
    task automatic send(input logic [23:0] b, input int n, input bit hold_off);
        int k;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk_sys);
            byte_valid = 1'b1;
            byte_data = b[8*i +: 8];
        end
        @(negedge clk_sys);
        byte_valid = 1'b0;
        byte_data = ~byte_data; // Stale byte not left on the line
        k = 0;
        repeat (2) @(negedge clk_sys);
        // Stands in for polling free space; also keeps store writes sparse
        while (hold_off && nv_busy && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
    endtask
endmodule

// [testbench/ccd_decoder_bench.sv]
/* Self-checking bench for the command decoder.
   Assumes the host model drives bytes and the store time is shortened. */
`timescale 1ns/100ps
module ccd_decoder_bench;
    import ccd_pkg::*;
    typedef struct packed {
        logic [1:0] n;
        logic [23:0] b;
        logic [7:0] kio, base, ma, mb;
        logic oc;
    } ccd_row_t;
    localparam ccd_row_t ROWS [19] = '{
        '{2'h1, 24'h22, 8'h01, 8'h50, 8'h00, 8'h00, 1'h0},
        '{2'h1, 24'h2A, 8'h01, 8'h50, 8'h00, 8'h00, 1'h1},
        '{2'h3, 24'h8D913C, 8'h01, 8'h3C, 8'h00, 8'h00, 1'h1},
        '{2'h2, 24'h9144, 8'h01, 8'h3C, 8'h00, 8'h00, 1'h1},
        '{2'h3, 24'h8DE301, 8'h01, 8'h3C, 8'h00, 8'h00, 1'h1},
        '{2'h3, 24'h8DE003, 8'h03, 8'h3C, 8'h00, 8'h00, 1'h1},
        '{2'h3, 24'h8DE301, 8'h03, 8'h3C, 8'h01, 8'h00, 1'h1},
        '{2'h3, 24'h8DE404, 8'h03, 8'h3C, 8'h01, 8'h00, 1'h1},
        '{2'h3, 24'h8DE007, 8'h07, 8'h3C, 8'h01, 8'h00, 1'h1},
        '{2'h3, 24'h8DE404, 8'h07, 8'h3C, 8'h01, 8'h04, 1'h1},
        '{2'h3, 24'h8DE305, 8'h07, 8'h3C, 8'h01, 8'h04, 1'h1},
        '{2'h3, 24'h8DE306, 8'h07, 8'h3C, 8'h06, 8'h04, 1'h1},
        '{2'h3, 24'h8DE302, 8'h07, 8'h3C, 8'h02, 8'h04, 1'h1},
        '{2'h3, 24'h8DE304, 8'h07, 8'h3C, 8'h04, 8'h04, 1'h1},
        '{2'h3, 24'h8DE300, 8'h07, 8'h3C, 8'h00, 8'h04, 1'h1},
        '{2'h3, 24'h8DE00F, 8'h0F, 8'h3C, 8'h00, 8'h04, 1'h1},
        '{2'h3, 24'h8DE005, 8'h0F, 8'h3C, 8'h00, 8'h04, 1'h1},
        '{2'h3, 24'h8DE000, 8'h00, 8'h3C, 8'h00, 8'h04, 1'h1},
        '{2'h3, 24'h8DE001, 8'h01, 8'h3C, 8'h00, 8'h04, 1'h1}};
    logic clk_sys, rst_n, byte_valid, key_pending, nv_busy, int_open_drain, int_o, int_oe;
    logic aux_en, a_en, b_en, c_en;
    logic a_pu, b_pu, a_out, b_out;
    ccd_keypad_t ksize;
    logic [7:0] byte_data, base_addr, keypad_io, pin_a_mode, pin_b_mode;
    int failures = 0;
    int compares = 0;
    ccd_host_model host_u (.clk_sys(clk_sys), .nv_busy(nv_busy), .byte_valid(byte_valid),
        .byte_data(byte_data));
    ccd_decoder #(.WRITE_CYC(20)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .byte_valid(byte_valid), .byte_data(byte_data), .key_pending(key_pending),
        .nv_busy(nv_busy), .nv_commit(), .int_open_drain(int_open_drain), .int_o(int_o),
        .int_oe(int_oe), .base_addr(base_addr), .keypad_io(keypad_io), .keypad_size(ksize),
        .aux_drain_output_en(aux_en), .general_pin_a_en(a_en), .general_pin_b_en(b_en),
        .general_pin_c_en(c_en), .general_pin_a_mode(pin_a_mode),
        .general_pin_b_mode(pin_b_mode), .general_pin_a_pullup(a_pu),
        .general_pin_b_pullup(b_pu), .general_pin_a_dir_out(a_out),
        .general_pin_b_dir_out(b_out), .analog_channel_a_en(),
        .analog_channel_b_en());
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic complete_run();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Keypad size that each legal keypad/IO value should give
    function automatic logic [2:0] size_of(input logic [7:0] k);
        case (k)
            8'h00: return CCD_KEY_4X4;
            8'h03: return CCD_KEY_4X2;
            8'h07: return CCD_KEY_4X1;
            8'h0F: return CCD_KEY_NONE;
            default: return CCD_KEY_4X3;
        endcase
    endfunction
    // Free-running clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Generous limit; the whole sequence needs about 400 cycles
    initial begin
        #500000;
        failures++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        key_pending = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 19; i++) begin
            host_u.send(ROWS[i].b, int'(ROWS[i].n), 1'b1);
            chk(keypad_io, ROWS[i].kio);
            chk(base_addr, ROWS[i].base);
            chk(pin_a_mode, ROWS[i].ma);
            chk(pin_b_mode, ROWS[i].mb);
            chk({7'h00, int_open_drain}, {7'h00, ROWS[i].oc});
            chk({4'h0, aux_en, a_en, b_en, c_en}, {4'h0, ROWS[i].kio != 8'h00,
                ROWS[i].kio inside {8'h03, 8'h07, 8'h0F}, ROWS[i].kio inside {8'h07, 8'h0F},
                ROWS[i].kio == 8'h0F});
            chk({5'h00, ksize}, {5'h00, size_of(ROWS[i].kio)});
            chk({4'h0, a_pu, a_out, b_pu, b_out}, {4'h0,
                ROWS[i].kio inside {8'h03, 8'h07, 8'h0F} && ROWS[i].ma inside {8'h04, 8'h06},
                ROWS[i].kio inside {8'h03, 8'h07, 8'h0F} && ROWS[i].ma == 8'h01,
                ROWS[i].kio inside {8'h07, 8'h0F} && ROWS[i].mb inside {8'h04, 8'h06},
                ROWS[i].kio inside {8'h07, 8'h0F} && ROWS[i].mb == 8'h01});
        end
        // Second keypad write lands while the store is still busy
        host_u.send(24'h8DE003, 3, 1'b0);
        chk({7'h00, nv_busy}, 8'h01);
        host_u.send(24'h8DE007, 3, 1'b1);
        chk(keypad_io, 8'h03);
        // Remembered drive type commits too; open drain idles released
        host_u.send(24'h8D2A, 2, 1'b0);
        chk({6'h00, int_open_drain, nv_busy}, 8'h03);
        chk({6'h00, int_o, int_oe}, 8'h02);
        // Pending key data under open drain, then push-pull with none pending
        key_pending = 1'b1;
        @(negedge clk_sys);
        chk({6'h00, int_o, int_oe}, 8'h01);
        host_u.send(24'h22, 1, 1'b1);
        key_pending = 1'b0;
        @(negedge clk_sys);
        chk({6'h00, int_o, int_oe}, 8'h03);
        // Reset in mid-run restores the delivery settings
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(keypad_io, 8'h01);
        chk(base_addr, 8'h50);
        chk({pin_a_mode[3:0], pin_b_mode[3:0]}, 8'h00);
        chk({6'h00, int_open_drain, nv_busy}, 8'h02);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        complete_run();
    end
endmodule
